// ==== src/sporeg_bank.v ====
// Purpose: scale step, pan and output size register bank
// Assumes: byte register port from the serial interface, same clock
// Notes: limits are computed after a settle delay, then clamped
`timescale 1ns/1ps
`include "sporeg_defines.vh"
module sporeg_bank #(
	parameter LIMIT_CYCLES = `SPO_LIMIT_CYCLES
) (
	input wire clock,
	input wire resetn,
	input wire regWrite,
	input wire regRead,
	input wire [7:0] regAddr,
	input wire [7:0] regWdata,
	output reg [7:0] regRdata,
	output reg regHit,
	input wire zoomMode,
	input wire [1:0] outputClockSelect,
	input wire progressiveInterlaceSelect,
	input wire tvStandardSelect,
	input wire [15:0] vssLimit,
	input wire [15:0] hpanLimit,
	input wire [15:0] vpanLimit,
	input wire errorClear,
	output reg sizeError,
	output reg limitBusy,
	output reg [15:0] verticalScaleStep,
	output reg [15:0] panX,
	output reg [15:0] panY,
	output reg panEnable,
	output reg [15:0] outputLinePixels,
	output reg [15:0] outputFrameLines,
	output reg modeCalc
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	localparam ST_IDLE = 2'd0;
	localparam ST_WAIT = 2'd1;
	localparam ST_CLAMP = 2'd2;
	reg [1:0] state;
	reg [31:0] waitCount;
	reg [3:0] modeLast;
	reg modeValid;
	reg [15:0] shadowVss;
	reg [15:0] shadowHpan;
	reg [15:0] shadowVpan;
	reg [15:0] shadowPix;
	reg [15:0] shadowLin;
	wire [3:0] modeNow;
	wire [15:0] defaultPixels;
	wire [15:0] defaultLines;
	wire [15:0] vssClamped;
	wire [15:0] hpanClamped;
	wire [15:0] vpanClamped;
	wire limitWrite;
	wire pixHiWrite;
	wire linHiWrite;
	wire [15:0] newPix;
	wire [15:0] newLin;
	wire pixInRange;
	wire linInRange;
	wire modeChange;
	assign modeNow = {tvStandardSelect, progressiveInterlaceSelect,
		outputClockSelect};
	// ----------------------------------------
	// Mode default table
	// ----------------------------------------
	sporeg_mode_defaults modeTable (
		.mode(modeNow),
		.pixels(defaultPixels),
		.lines(defaultLines)
	);
	// Symmetric signed clamp to the computed limit
	function [15:0] clampSigned;
		input [15:0] value;
		input [15:0] limit;
		reg signed [15:0] sv;
		reg signed [15:0] lim;
		begin
			sv = value;
			lim = limit;
			if (lim < 0)
				lim = -lim;
			if (sv > lim)
				clampSigned = lim;
			else if (sv < -lim)
				clampSigned = -lim;
			else
				clampSigned = value;
		end
	endfunction
	assign vssClamped = clampSigned(verticalScaleStep, vssLimit);
	assign hpanClamped = clampSigned(shadowHpan, hpanLimit);
	assign vpanClamped = clampSigned(shadowVpan, vpanLimit);
	// Writes that start a limit computation
	assign limitWrite = regWrite && (regAddr >= `SPO_VSS_LO) &&
		(regAddr <= `SPO_VPAN_HI);
	assign pixHiWrite = regWrite && (regAddr == `SPO_PIX_HI);
	assign linHiWrite = regWrite && (regAddr == `SPO_LIN_HI);
	assign newPix = {regWdata, shadowPix[7:0]};
	assign newLin = {regWdata, shadowLin[7:0]};
	assign pixInRange = (newPix >= `SPO_SIZE_MIN) &&
		(newPix <= `SPO_SIZE_MAX);
	assign linInRange = (newLin >= `SPO_SIZE_MIN) &&
		(newLin <= `SPO_SIZE_MAX);
	assign modeChange = modeValid && (modeNow != modeLast);
	// ----------------------------------------
	// Register writes and limit controller
	// ----------------------------------------
	// Byte writes, settle timer, clamp write-back
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			state <= ST_IDLE;
			waitCount <= 32'h0000_0000;
			verticalScaleStep <= 16'h0000;
			shadowHpan <= 16'h0000;
			shadowVpan <= 16'h0000;
			shadowPix <= `SPO_PIX_RESET;
			shadowLin <= `SPO_LIN_RESET;
			outputLinePixels <= `SPO_PIX_RESET;
			outputFrameLines <= `SPO_LIN_RESET;
			sizeError <= 1'b0;
			modeCalc <= 1'b0;
			modeLast <= 4'h0;
			modeValid <= 1'b0;
		end
		else
		begin
			modeCalc <= 1'b0;
			modeLast <= modeNow;
			modeValid <= 1'b1;
			if (errorClear)
				sizeError <= 1'b0;
			case (regWrite ? regAddr : 8'h00)
				`SPO_VSS_LO: verticalScaleStep[7:0] <= regWdata;
				`SPO_VSS_HI: verticalScaleStep[15:8] <= regWdata;
				`SPO_HPAN_LO: shadowHpan[7:0] <= regWdata;
				`SPO_HPAN_HI: shadowHpan[15:8] <= regWdata;
				`SPO_VPAN_LO: shadowVpan[7:0] <= regWdata;
				`SPO_VPAN_HI: shadowVpan[15:8] <= regWdata;
				`SPO_PIX_LO: shadowPix[7:0] <= regWdata;
				`SPO_PIX_HI: shadowPix[15:8] <= regWdata;
				`SPO_LIN_LO: shadowLin[7:0] <= regWdata;
				`SPO_LIN_HI: shadowLin[15:8] <= regWdata;
				default: ;
			endcase
			// Size commit on high byte; error set wins over clear
			if (pixHiWrite)
			begin
				if (pixInRange)
				begin
					outputLinePixels <= newPix;
					modeCalc <= 1'b1;
				end
				else
					sizeError <= 1'b1;
			end
			if (linHiWrite)
			begin
				if (linInRange)
				begin
					outputFrameLines <= newLin;
					modeCalc <= 1'b1;
				end
				else
					sizeError <= 1'b1;
			end
			// Output mode change reloads both sizes
			if (modeChange)
			begin
				outputLinePixels <= defaultPixels;
				outputFrameLines <= defaultLines;
				shadowPix <= defaultPixels;
				shadowLin <= defaultLines;
				modeCalc <= 1'b1;
			end
			// Limit computation sequence
			case (state)
				ST_IDLE:
				begin
					if (limitWrite)
					begin
						state <= ST_WAIT;
						waitCount <= 32'h0000_0000;
					end
				end
				ST_WAIT:
				begin
					if (limitWrite)
						waitCount <= 32'h0000_0000;
					else if (waitCount >= LIMIT_CYCLES - 1)
						state <= ST_CLAMP;
					else
						waitCount <= waitCount + 32'h0000_0001;
				end
				ST_CLAMP:
				begin
					state <= ST_IDLE;
					if (!limitWrite)
					begin
						verticalScaleStep <= vssClamped;
						shadowHpan <= hpanClamped;
						shadowVpan <= vpanClamped;
					end
					else
						state <= ST_WAIT;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
	// ----------------------------------------
	// Pan outputs
	// ----------------------------------------
	// Pan drives the window only in zoom mode
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			panX <= 16'h0000;
			panY <= 16'h0000;
			panEnable <= 1'b0;
			limitBusy <= 1'b0;
		end
		else
		begin
			panEnable <= zoomMode;
			panX <= zoomMode ? shadowHpan : 16'h0000;
			panY <= zoomMode ? shadowVpan : 16'h0000;
			// Busy from the edge after the write that starts a wait
			limitBusy <= (state != ST_IDLE) || limitWrite;
		end
	end
	// ----------------------------------------
	// Read port
	// ----------------------------------------
	// Registered read data, zero outside the bank
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			regRdata <= 8'h00;
			regHit <= 1'b0;
		end
		else
		begin
			regHit <= regRead && (regAddr >= `SPO_VSS_LO) &&
				(regAddr <= `SPO_LIN_HI);
			case (regRead ? regAddr : 8'h00)
				`SPO_VSS_LO: regRdata <= verticalScaleStep[7:0];
				`SPO_VSS_HI: regRdata <= verticalScaleStep[15:8];
				`SPO_HPAN_LO: regRdata <= shadowHpan[7:0];
				`SPO_HPAN_HI: regRdata <= shadowHpan[15:8];
				`SPO_VPAN_LO: regRdata <= shadowVpan[7:0];
				`SPO_VPAN_HI: regRdata <= shadowVpan[15:8];
				`SPO_PIX_LO: regRdata <= outputLinePixels[7:0];
				`SPO_PIX_HI: regRdata <= outputLinePixels[15:8];
				`SPO_LIN_LO: regRdata <= outputFrameLines[7:0];
				`SPO_LIN_HI: regRdata <= outputFrameLines[15:8];
				default: regRdata <= 8'h00;
			endcase
		end
	end
endmodule // sporeg_bank

// ==== src/sporeg_defines.vh ====
// Purpose: constants for the scale, pan and output size register bank
// Assumes: byte-wide serial register port, 40 MHz clock
// Notes: offsets are byte addresses on the register port
`ifndef SPOREG_DEFINES_VH
`define SPOREG_DEFINES_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define SPO_VSS_LO 8'h6e
`define SPO_VSS_HI 8'h6f
`define SPO_HPAN_LO 8'h70
`define SPO_HPAN_HI 8'h71
`define SPO_VPAN_LO 8'h72
`define SPO_VPAN_HI 8'h73
`define SPO_PIX_LO 8'h74
`define SPO_PIX_HI 8'h75
`define SPO_LIN_LO 8'h76
`define SPO_LIN_HI 8'h77
// ----------------------------------------
// Reset values and ranges
// ----------------------------------------
`define SPO_PIX_RESET 16'h0292
`define SPO_LIN_RESET 16'h019c
`define SPO_SIZE_MIN 16'h0080
`define SPO_SIZE_MAX 16'h07ff
// ----------------------------------------
// Timing
// ----------------------------------------
`define SPO_CLK_HZ 40000000
`define SPO_LIMIT_MS 25
`define SPO_LIMIT_CYCLES (`SPO_CLK_HZ / 1000 * `SPO_LIMIT_MS)
`endif

// ==== src/sporeg_mode_defaults.v ====
// Purpose: default output size for each output mode
// Assumes: mode is {tv standard, progressive, clock select[1:0]}
// Notes: combinational lookup
`timescale 1ns/1ps
module sporeg_mode_defaults (
	input wire [3:0] mode,
	output reg [15:0] pixels,
	output reg [15:0] lines
);
	// ----------------------------------------
	// Mode table
	// ----------------------------------------
	// Low three mode bits select one table row; the tv standard bit is not decoded
	always @*
	begin
		case (mode[2:0])
			3'd0:
			begin
				pixels = 16'h0292;
				lines = 16'h019c;
			end
			3'd1:
			begin
				pixels = 16'h0334;
				lines = 16'h01f0;
			end
			3'd2:
			begin
				pixels = 16'h0280;
				lines = 16'h01e0;
			end
			3'd3:
			begin
				pixels = 16'h0320;
				lines = 16'h0258;
			end
			3'd4:
			begin
				pixels = 16'h038c;
				lines = 16'h021c;
			end
			3'd5:
			begin
				pixels = 16'h0292;
				lines = 16'h019c;
			end
			3'd6:
			begin
				pixels = 16'h0392;
				lines = 16'h019c;
			end
			3'd7:
			begin
				pixels = 16'h0392;
				lines = 16'h01f0;
			end
			default:
			begin
				pixels = `SPO_PIX_RESET;
				lines = `SPO_LIN_RESET;
			end
		endcase
	end
endmodule // sporeg_mode_defaults

// ==== tb/sporeg_bank_chk.sv ====
// Purpose: port checks for the register bank
// Assumes: one clock, reset active low
// Notes: limit wait bounded by a cycle counter
`timescale 1ns/1ps
module sporeg_bank_chk #(
	parameter int LIMIT_CYCLES = 16
) (
	input wire clock,
	input wire resetn,
	input wire regWrite,
	input wire regRead,
	input wire [7:0] regAddr,
	input wire [7:0] regWdata,
	input wire [7:0] regRdata,
	input wire regHit,
	input wire zoomMode,
	input wire [1:0] outputClockSelect,
	input wire progressiveInterlaceSelect,
	input wire tvStandardSelect,
	input wire sizeError,
	input wire limitBusy,
	input wire [15:0] panX,
	input wire [15:0] panY,
	input wire [15:0] outputLinePixels,
	input wire [15:0] outputFrameLines,
	input wire modeCalc
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);
	// Address decode and mode fields
	wire [3:0] mode = {tvStandardSelect, progressiveInterlaceSelect,
		outputClockSelect};
	wire mapped = regAddr >= 8'h6e && regAddr <= 8'h77;
	wire limitWrite = regWrite && regAddr >= 8'h6e && regAddr <= 8'h73;
	logic [31:0] busyCount;
	// Cycles spent waiting on a limit
	always @(posedge clock or negedge resetn)
		if (!resetn)
			busyCount <= 32'h0000_0000;
		else if (limitWrite || !limitBusy)
			busyCount <= 32'h0000_0000;
		else
			busyCount <= busyCount + 32'h0000_0001;
	property p_hit;
		regRead && mapped |=> regHit;
	endproperty
	a_hit: assert property (p_hit)
		else $error("no hit on mapped read");
	property p_miss;
		regRead && !mapped |=> !regHit && regRdata == 8'h00;
	endproperty
	a_miss: assert property (p_miss)
		else $error("unmapped read answered");
	property p_pan;
		!zoomMode [*2] |-> panX == 16'h0000 && panY == 16'h0000;
	endproperty
	a_pan: assert property (p_pan)
		else $error("pan applied outside zoom");
	property p_range;
		outputLinePixels >= 16'h0080 && outputLinePixels <= 16'h07ff &&
		outputFrameLines >= 16'h0080 && outputFrameLines <= 16'h07ff;
	endproperty
	a_range: assert property (p_range)
		else $error("output size out of range");
	property p_pix_bad;
		regWrite && regAddr == 8'h75 && regWdata > 8'h07 && $stable(mode)
		|=> sizeError && $stable(outputLinePixels);
	endproperty
	a_pix_bad: assert property (p_pix_bad)
		else $error("bad pixel count not refused");
	property p_pix_set;
		regWrite && regAddr == 8'h75 && regWdata inside {[8'h01:8'h07]}
		&& $stable(mode)
		|=> modeCalc && outputLinePixels[15:8] == $past(regWdata);
	endproperty
	a_pix_set: assert property (p_pix_set)
		else $error("pixel count not committed");
	property p_busy;
		limitWrite |=> limitBusy;
	endproperty
	a_busy: assert property (p_busy)
		else $error("limit wait not started");
	property p_wait;
		busyCount <= LIMIT_CYCLES + 3;
	endproperty
	a_wait: assert property (p_wait)
		else $error("limit wait too long");
	c_clamp: cover property ($fell(limitBusy));
	c_err: cover property ($rose(sizeError));
	c_mode: cover property (modeCalc);
endmodule // sporeg_bank_chk

bind sporeg_bank sporeg_bank_chk #(.LIMIT_CYCLES(LIMIT_CYCLES)) chk_u (.*);

// ==== tb/sporeg_host.sv ====
// Purpose: host model on the byte register port
// Assumes: requests launched 2 ns after a rising edge
// Notes: released address and data lines show inverted values; strobes go low
`timescale 1ns/1ps
module sporeg_host (
	input wire clock,
	output logic regWrite = 1'b0,
	output logic regRead = 1'b0,
	output logic [7:0] regAddr = 8'h00,
	output logic [7:0] regWdata = 8'h00,
	input wire [7:0] regRdata,
	input wire regHit
);
	// One byte access held through the taking edge
	task automatic xfer(input logic w, input logic [7:0] a, d);
		@(posedge clock);
		#2;
		regWrite = w;
		regRead = !w;
		regAddr = a;
		regWdata = d;
		@(posedge clock);
		#2;
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = ~a;
		regWdata = ~d;
	endtask
	// Low byte first, then high byte
	task automatic wr16(input logic [7:0] a, input logic [15:0] v);
		xfer(1'b1, a, v[7:0]);
		xfer(1'b1, a + 8'h01, v[15:8]);
	endtask
	task automatic rd16(input logic [7:0] a, output logic [15:0] v);
		xfer(1'b0, a, 8'h00);
		v[7:0] = regRdata;
		xfer(1'b0, a + 8'h01, 8'h00);
		v[15:8] = regRdata;
	endtask
endmodule // sporeg_host

// ==== tb/sporeg_bank_bench.sv ====
// Purpose: self-checking bench for the register bank
// Assumes: host model drives the register port
// Notes: limit wait shortened to 16 cycles
`timescale 1ns/1ps
module sporeg_bank_bench;
	localparam int LIM = 16;
	typedef struct {logic [7:0] a; logic [15:0] v, l, e; logic err;}
		sporeg_row_t;
	sporeg_row_t rows[8] = '{
		'{8'h6e, 16'h1234, 16'h7fff, 16'h1234, 1'b0},
		'{8'h6e, 16'hf000, 16'h0100, 16'hff00, 1'b0},
		'{8'h70, 16'h0000, 16'h0400, 16'h0000, 1'b0},
		'{8'h70, 16'h2000, 16'h0400, 16'h0400, 1'b0},
		'{8'h72, 16'h8000, 16'h0400, 16'hfc00, 1'b0},
		'{8'h74, 16'h0080, 16'h0000, 16'h0080, 1'b0},
		'{8'h74, 16'h0800, 16'h0000, 16'h0080, 1'b1},
		'{8'h76, 16'h007f, 16'h0000, 16'h019c, 1'b1}};
	logic [15:0] pixTab[8] = '{16'h0292, 16'h0334, 16'h0280, 16'h0320,
		16'h038c, 16'h0292, 16'h0392, 16'h0392};
	logic [15:0] linTab[8] = '{16'h019c, 16'h01f0, 16'h01e0, 16'h0258,
		16'h021c, 16'h019c, 16'h019c, 16'h01f0};
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic zoomMode = 1'b1;
	logic progressiveInterlaceSelect = 1'b0;
	logic tvStandardSelect = 1'b0;
	logic errorClear = 1'b0;
	logic [1:0] outputClockSelect = 2'h0;
	logic [15:0] lim = 16'h7fff;
	logic [15:0] d;
	wire regWrite, regRead, regHit, sizeError, limitBusy, panEnable, modeCalc;
	wire [7:0] regAddr, regWdata, regRdata;
	wire [15:0] verticalScaleStep, panX, panY;
	wire [15:0] outputLinePixels, outputFrameLines;
	int badCount = 0;
	int compares = 0;
	// Design, host model and clock
	sporeg_bank #(.LIMIT_CYCLES(LIM)) dut_u (.*, .vssLimit(lim),
		.hpanLimit(lim), .vpanLimit(lim));
	sporeg_host host_u (.*);
	always #12.5 clock = ~clock;
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask
	task automatic check(input string n, input logic [15:0] got, exp);
		compares++;
		if (got !== exp)
		begin
			badCount++;
			$display("mismatch %s expected %h seen %h", n, exp, got);
		end
	endtask
	function automatic logic [15:0] portOf(input logic [7:0] a);
		case (a)
			8'h6e: return verticalScaleStep;
			8'h70: return panX;
			8'h72: return panY;
			8'h74: return outputLinePixels;
			default: return outputFrameLines;
		endcase
	endfunction
	task automatic printVerdict;
		$display("comparisons %0d mismatches %0d", compares, badCount);
		if (badCount == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Table rows, then zoom, unmapped, mode and reset cases
	initial
	begin
		tick(20);
		resetn = 1'b1;
		foreach (rows[i])
		begin
			lim = rows[i].l;
			errorClear = 1'b1;
			tick(1);
			errorClear = 1'b0;
			host_u.wr16(rows[i].a, rows[i].v);
			tick(LIM + 4);
			host_u.rd16(rows[i].a, d);
			check("value", portOf(rows[i].a), rows[i].e);
			check("error", 16'(sizeError), 16'(rows[i].err));
			if (rows[i].a < 8'h74)
				check("readback", d, rows[i].e);
		end
		zoomMode = 1'b0;
		tick(3);
		check("panX", panX, 16'h0000);
		check("panY", panY, 16'h0000);
		check("panEnable", 16'(panEnable), 16'h0000);
		host_u.xfer(1'b0, 8'h78, 8'h00);
		check("unmapped", {7'h00, regHit, regRdata}, 16'h0000);
		for (int m = 1; m < 8; m++)
		begin
			{progressiveInterlaceSelect, outputClockSelect} = 3'(m);
			tick(3);
			check("pixels", outputLinePixels, pixTab[m]);
			check("lines", outputFrameLines, linTab[m]);
		end
		// Standard field alone must reload a hand-written size
		host_u.wr16(8'h74, 16'h0100);
		tick(2);
		check("pixWritten", outputLinePixels, 16'h0100);
		tvStandardSelect = 1'b1;
		tick(3);
		check("pixStd", outputLinePixels, pixTab[7]);
		check("linStd", outputFrameLines, linTab[7]);
		resetn = 1'b0;
		#1;
		check("pixReset", outputLinePixels, 16'h0292);
		check("linReset", outputFrameLines, 16'h019c);
		tick(2);
		resetn = 1'b1;
		tick(3);
		check("pixAfter", outputLinePixels, 16'h0292);
		printVerdict();
	end
	// Watchdog against a hang
	initial
	begin
		#(25 * 4000);
		badCount++;
		printVerdict();
	end
endmodule // sporeg_bank_bench
